// ===== anpr_consts.svh
// Purpose: Offsets, field positions and reset values of the next page regs
// Assumes: 16-bit register words, word-indexed addresses
// Notes:   Definitions only
`ifndef ANPR_CONSTS_SVH
`define ANPR_CONSTS_SVH
`define ANPR_ADDR_W          16
`define ANPR_DATA_W          16
`define ANPR_OFF_TX_LOW      16'h0208
`define ANPR_OFF_TX_MID      16'h0209
`define ANPR_OFF_TX_HIGH     16'h020a
`define ANPR_OFF_RX_LOW      16'h020b
`define ANPR_OFF_RX_MID      16'h020c
`define ANPR_OFF_RX_HIGH     16'h020d
`define ANPR_RST_TX_LOW      16'h2001
`define ANPR_RST_TX_MID      16'h0000
`define ANPR_RST_TX_HIGH     16'h0000
`define ANPR_RST_RX          16'h0000
`define ANPR_BIT_REQ         15
`define ANPR_BIT_ACK         14
`define ANPR_BIT_TYPE        13
`define ANPR_BIT_ACK2        12
`define ANPR_BIT_TOGGLE      11
`define ANPR_CODE_MSB        10
`define ANPR_TX_LOW_WMASK    16'hb7ff
`define ANPR_CODE_NULL       11'h001
`define ANPR_CODE_OUI_MSG    11'h005
`define ANPR_CODE_DEV_ID     11'h006
`endif

// ===== anpr_pkg.sv
// Purpose: Types shared by the next page register files
// Assumes: Constants come from anpr_consts.svh
// Notes:   Page word order is low, mid, high
package anpr_pkg;
  typedef logic [15:0] anpr_word_t;
  typedef logic [47:0] anpr_page_t;
endpackage

// ===== anpr_rx_if.sv
// Purpose: Carrier between the register bank and the partner page holder
// Assumes: Single clock domain
// Notes:   Capture is a one-cycle pulse
`timescale 1ns/1ps
interface anpr_rx_if;
  logic                capture;
  anpr_pkg::anpr_word_t held_mid;
  anpr_pkg::anpr_word_t held_high;
  modport bank   (output capture, input held_mid, input held_high);
  modport holder (input capture, output held_mid, output held_high);
endinterface // anpr_rx_if

// ===== anpr_rx_hold.sv
// Purpose: Holds the partner upper words captured on a low-word read
// Assumes: Live partner page is synchronous to sys_clk_in
// Notes:   Reset to zero
`timescale 1ns/1ps
`include "anpr_consts.svh"
module anpr_rx_hold (
  input  wire logic                 sys_clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 an_rst_in,
  input  anpr_pkg::anpr_page_t      live_page_in,
  anpr_rx_if.holder                 rx
);
  anpr_pkg::anpr_word_t mid_q;
  anpr_pkg::anpr_word_t mid_d;
  anpr_pkg::anpr_word_t high_q;
  anpr_pkg::anpr_word_t high_d;

  // Snapshot the upper words so one page reads consistently
  always_comb begin
    mid_d  = mid_q;
    high_d = high_q;
    if (an_rst_in) begin
      mid_d  = `ANPR_RST_RX; // [RL13]
      high_d = `ANPR_RST_RX; // [RL13]
    end else if (rx.capture) begin
      mid_d  = live_page_in[31:16]; // [RL10]
      high_d = live_page_in[47:32]; // [RL10]
    end
  end

  // Registers only
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mid_q  <= `ANPR_RST_RX;
      high_q <= `ANPR_RST_RX;
    end else begin
      mid_q  <= mid_d;
      high_q <= high_d;
    end
  end

  assign rx.held_mid  = mid_q;
  assign rx.held_high = high_q;
endmodule // anpr_rx_hold

// ===== anpr_regs.sv
// Purpose: Autonegotiation next page transmit and partner receive registers
// Assumes: Plain register port, read data valid the cycle after the strobe
// Notes:   Committed page only changes on a low outgoing word write or an autonegotiation reset
`timescale 1ns/1ps
`include "anpr_consts.svh"

// Operation
// [RL1] Low outgoing word resets to 2001 on power-up or autonegotiation reset
// [RL2] Software writes mid and high outgoing words before the low word
// [RL3] Low word bit 15 is writable more-pages request, reset 0
// [RL4] Low word bit 14 acknowledge is read-only, reset 0, writes ignored
// [RL5] Low word bit 13 page type, writable, reset 1, 1 means message
// [RL6] Low word bit 12 second acknowledge, writable, reset 0
// [RL7] Low word bit 11 sync toggle always reads 0
// [RL8] Low word bits 10:0 code field, writable, reset 1
// [RL9] Mid and high outgoing words are 16-bit read/write, reset 0
// [RL10] Reading partner low word captures partner mid and high words
// [RL11] Partner mid word reads the held value, not the live one
// [RL12] Partner low word shows request, ack, type, ack2, toggle, code read-only
// [RL13] Partner words reset to zero and ignore writes; the partner low word reads the live page and is not reset
// [RL14] Writing low outgoing word commits the whole 48-bit page
module anpr_regs (
  input  wire logic                         sys_clk_in,
  input  wire logic                         sys_rst_in,
  input  wire logic                         an_rst_in,
  input  wire logic [`ANPR_ADDR_W-1:0]      reg_addr_in,
  input  wire logic [`ANPR_DATA_W-1:0]      reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  input  anpr_pkg::anpr_page_t              rx_page_in,
  input  wire logic                         tx_ack_in,
  output logic      [`ANPR_DATA_W-1:0]      reg_rdata_out,
  output anpr_pkg::anpr_page_t              tx_page_out,
  output logic                              tx_commit_out
);
  anpr_rx_if rx ();

  anpr_pkg::anpr_word_t tx_low_q;
  anpr_pkg::anpr_word_t tx_low_d;
  anpr_pkg::anpr_word_t tx_mid_q;
  anpr_pkg::anpr_word_t tx_mid_d;
  anpr_pkg::anpr_word_t tx_high_q;
  anpr_pkg::anpr_word_t tx_high_d;
  anpr_pkg::anpr_page_t page_q;
  anpr_pkg::anpr_page_t page_d;
  logic                 commit_q;
  logic                 commit_d;
  logic                 ack_q;
  logic                 ack_d;
  anpr_pkg::anpr_word_t rdata_q;
  anpr_pkg::anpr_word_t rdata_d;
  anpr_pkg::anpr_word_t tx_low_view;
  anpr_pkg::anpr_word_t rx_low_view;
  logic                 wr_low;
  logic                 wr_mid;
  logic                 wr_high;
  anpr_pkg::anpr_word_t low_wr_bits;

  // Named fields of the outgoing words
  logic                 tx_more_pages_request;
  logic                 tx_acknowledge;
  logic                 tx_page_type;
  logic                 tx_second_acknowledge;
  logic                 tx_sync_toggle;
  logic [10:0]          tx_code_field;
  anpr_pkg::anpr_word_t tx_extra_field_one;
  anpr_pkg::anpr_word_t tx_extra_field_two;

  // Named fields of the partner words
  logic                 rx_more_pages_request;
  logic                 rx_acknowledge;
  logic                 rx_page_type;
  logic                 rx_second_acknowledge;
  logic                 rx_sync_toggle;
  logic [10:0]          rx_code_field;
  anpr_pkg::anpr_word_t rx_extra_field_one;

  // Writable bits of the low outgoing word
  localparam anpr_pkg::anpr_word_t LowWrMask = `ANPR_TX_LOW_WMASK;

  // One gate per bit; ack and toggle positions always drop the write
  for (genvar b = 0; b < 16; b++) begin : g_low_wr
    assign low_wr_bits[b] = reg_wdata_in[b] & LowWrMask[b]; // [RL4] [RL7]
  end

  // Outgoing fields; ack comes from arbitration, toggle never reads back
  assign tx_more_pages_request = tx_low_q[`ANPR_BIT_REQ]; // [RL3]
  assign tx_acknowledge        = ack_q; // [RL4]
  assign tx_page_type          = tx_low_q[`ANPR_BIT_TYPE]; // [RL5]
  assign tx_second_acknowledge = tx_low_q[`ANPR_BIT_ACK2]; // [RL6]
  assign tx_sync_toggle        = 1'b0; // [RL7]
  assign tx_code_field         = tx_low_q[`ANPR_CODE_MSB:0]; // [RL8]
  assign tx_extra_field_one    = tx_mid_q; // [RL9]
  assign tx_extra_field_two    = tx_high_q; // [RL9]

  // Partner fields; low word is live, middle word is the snapshot
  assign rx_more_pages_request = rx_page_in[`ANPR_BIT_REQ]; // [RL12]
  assign rx_acknowledge        = rx_page_in[`ANPR_BIT_ACK]; // [RL12]
  assign rx_page_type          = rx_page_in[`ANPR_BIT_TYPE]; // [RL12]
  assign rx_second_acknowledge = rx_page_in[`ANPR_BIT_ACK2]; // [RL12]
  assign rx_sync_toggle        = rx_page_in[`ANPR_BIT_TOGGLE]; // [RL12]
  assign rx_code_field         = rx_page_in[`ANPR_CODE_MSB:0]; // [RL12]
  assign rx_extra_field_one    = rx.held_mid; // [RL11]

  // Write decode; partner addresses decode to nothing on a write
  assign wr_low  = reg_wr_in && (reg_addr_in == `ANPR_OFF_TX_LOW);
  assign wr_mid  = reg_wr_in && (reg_addr_in == `ANPR_OFF_TX_MID);
  assign wr_high = reg_wr_in && (reg_addr_in == `ANPR_OFF_TX_HIGH);

  // Capture strobe for the holder; same cycle as the low-word read
  assign rx.capture = reg_rd_in && (reg_addr_in == `ANPR_OFF_RX_LOW); // [RL10]

  anpr_rx_hold u_hold (
    .sys_clk_in   (sys_clk_in),
    .sys_rst_in   (sys_rst_in),
    .an_rst_in    (an_rst_in),
    .live_page_in (rx_page_in),
    .rx           (rx.holder)
  );

  // Outgoing word storage; ack and toggle bits are never stored
  always_comb begin
    tx_low_d  = tx_low_q;
    tx_mid_d  = tx_mid_q;
    tx_high_d = tx_high_q;
    if (an_rst_in) begin
      tx_low_d  = `ANPR_RST_TX_LOW; // [RL1]
      tx_mid_d  = `ANPR_RST_TX_MID; // [RL9]
      tx_high_d = `ANPR_RST_TX_HIGH; // [RL9]
    end else begin
      if (wr_low) begin
        // Mask keeps bits 15, 13, 12 and 10:0 writable
        tx_low_d = low_wr_bits; // [RL3] [RL5] [RL6] [RL8]
      end
      if (wr_mid) begin
        tx_mid_d = reg_wdata_in; // [RL9]
      end
      if (wr_high) begin
        tx_high_d = reg_wdata_in; // [RL9]
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_low_q  <= `ANPR_RST_TX_LOW; // [RL1]
      tx_mid_q  <= `ANPR_RST_TX_MID;
      tx_high_q <= `ANPR_RST_TX_HIGH;
    end else begin
      tx_low_q  <= tx_low_d;
      tx_mid_q  <= tx_mid_d;
      tx_high_q <= tx_high_d;
    end
  end

  // Acknowledge bit mirrors the arbitration side, software cannot write it
  always_comb begin
    ack_d = an_rst_in ? 1'b0 : tx_ack_in; // [RL4]
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Commit the page on the low write; the write data is taken directly so
  // the committed low word matches what the register holds next cycle.
  // Mid/high must already be loaded, the ordering is software's job.
  always_comb begin
    page_d   = page_q;
    commit_d = 1'b0;
    if (an_rst_in) begin
      page_d = {`ANPR_RST_TX_HIGH, `ANPR_RST_TX_MID, `ANPR_RST_TX_LOW};
    end else if (wr_low) begin
      page_d   = {tx_high_q, tx_mid_q,
                  low_wr_bits}; // [RL14] [RL2]
      commit_d = 1'b1; // [RL14]
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      page_q   <= {`ANPR_RST_TX_HIGH, `ANPR_RST_TX_MID, `ANPR_RST_TX_LOW};
      commit_q <= 1'b0;
    end else begin
      page_q   <= page_d;
      commit_q <= commit_d;
    end
  end

  // Read views of the low words
  always_comb begin
    // Stored ack and toggle bits are ignored; the fields replace them
    tx_low_view = {tx_more_pages_request, tx_acknowledge, tx_page_type,
                   tx_second_acknowledge, tx_sync_toggle,
                   tx_code_field}; // [RL4] [RL7]
    // Live partner low word, field for field
    rx_low_view = {rx_more_pages_request, rx_acknowledge, rx_page_type,
                   rx_second_acknowledge, rx_sync_toggle,
                   rx_code_field}; // [RL12]
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `ANPR_OFF_TX_LOW:  rdata_d = tx_low_view;
        `ANPR_OFF_TX_MID:  rdata_d = tx_extra_field_one; // [RL9]
        `ANPR_OFF_TX_HIGH: rdata_d = tx_extra_field_two; // [RL9]
        `ANPR_OFF_RX_LOW:  rdata_d = rx_low_view; // [RL12]
        `ANPR_OFF_RX_MID:  rdata_d = rx_extra_field_one; // [RL11]
        `ANPR_OFF_RX_HIGH: rdata_d = rx.held_high; // [RL11]
        default:           rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= `ANPR_RST_RX; // [RL13]
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign tx_page_out   = page_q;
  assign tx_commit_out = commit_q;
endmodule // anpr_regs

// ===== anpr_far.sv
// Purpose: Partner page source standing in for the link side
// Assumes: Pages change only on system clock edges
// Notes:   Steps each cycle while hop is high
`timescale 1ns/1ps
module anpr_far (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            hop_in,
  output anpr_pkg::anpr_page_t page_out,
  output logic                 ack_out
);
  // Scrambled step so all three words move on every hop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_out <= 48'h0;
      ack_out  <= 1'b0;
    end else if (hop_in) begin
      page_out <= {page_out[46:0], ~page_out[47]} ^ 48'h1234_5678_9abc;
      ack_out  <= ~ack_out;
    end
  end
endmodule // anpr_far

// ===== anpr_regs_assertions.sv
// Purpose: Timing checks on the next page register port
// Assumes: Reads answered one cycle later, a gap between strobes
// Notes:   Bound to every register bank instance
`timescale 1ns/1ps
module anpr_chk (
  input wire logic           sys_clk_in,
  input wire logic           sys_rst_in,
  input wire logic           an_rst_in,
  input wire logic [15:0]    reg_addr_in,
  input wire logic [15:0]    reg_wdata_in,
  input wire logic           reg_wr_in,
  input wire logic           reg_rd_in,
  input anpr_pkg::anpr_page_t rx_page_in,
  input wire logic           tx_ack_in,
  input wire logic [15:0]    reg_rdata_out,
  input anpr_pkg::anpr_page_t tx_page_out,
  input wire logic           tx_commit_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Accesses that an autonegotiation reset would swallow are left out
  wire logic wr_low = reg_wr_in && reg_addr_in == 16'h0208 && !an_rst_in;
  wire logic rd_low = reg_rd_in && reg_addr_in == 16'h020b && !an_rst_in;
  AST_COMMIT: assert property (tx_commit_out == $past(wr_low))
    else $error("commit pulse not tied to low write");
  AST_PAGE: assert property (wr_low |=>
    tx_page_out[15:0] == ($past(reg_wdata_in) & 16'hb7ff))
    else $error("committed low word wrong");
  AST_HOLD: assert property ($changed(tx_page_out) |->
    tx_commit_out || $past(an_rst_in)) else $error("page moved alone");
  AST_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data outside a read");
  AST_TOG: assert property (reg_rd_in && reg_addr_in == 16'h0208 |=>
    !reg_rdata_out[11]) else $error("toggle bit read as 1");
  AST_RXLOW: assert property (rd_low |=>
    reg_rdata_out == $past(rx_page_in[15:0])) else $error("partner low");
  AST_RXMID: assert property (rd_low ##2
    (reg_rd_in && reg_addr_in == 16'h020c) |=>
    reg_rdata_out == $past(rx_page_in[31:16], 3)) else $error("held mid");
  AST_ANRST: assert property (an_rst_in |=>
    tx_page_out == 48'h2001 && !tx_commit_out) else $error("an reset");
endmodule // anpr_chk
bind anpr_regs anpr_chk chk_u (.*);

// ===== test_autoneg_next_page_regs.sv
// Purpose: Self-checking bench for the next page register bank
// Assumes: Strobes one cycle with a gap cycle between accesses
// Notes:   Random words come from an LFSR seeded with 11
`timescale 1ns/1ps
module test_autoneg_next_page_regs;
  logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, an_rst_in = 1'b0, hop = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, tx_ack_in, tx_commit_out;
  logic [15:0] reg_addr_in = 16'h0, reg_wdata_in = 16'h0, reg_rdata_out;
  logic [15:0] s, m, h, l, d;
  anpr_pkg::anpr_page_t rx_page_in, tx_page_out, snap, cap;
  int err_count = 0, cmp_count = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  anpr_regs dut_u (
    .sys_clk_in    (sys_clk_in),
    .sys_rst_in    (sys_rst_in),
    .an_rst_in     (an_rst_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .rx_page_in    (rx_page_in),
    .tx_ack_in     (tx_ack_in),
    .reg_rdata_out (reg_rdata_out),
    .tx_page_out   (tx_page_out),
    .tx_commit_out (tx_commit_out)
  );
  anpr_far far_u (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .hop_in(hop),
    .page_out(rx_page_in), .ack_out(tx_ack_in));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Bits 14 and 11 never hold what software wrote
  function automatic logic [15:0] low_rb(input logic [15:0] w, input logic a);
    return (w & 16'hb7ff) | {1'b0, a, 14'h0};
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge sys_clk_in) begin
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_wr_in    <= 1'b1;
    end
    @(posedge sys_clk_in) reg_wr_in <= 1'b0;
  endtask
  // Snap keeps the live partner page of the strobe cycle
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge sys_clk_in) begin
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
    end
    #1 snap = rx_page_in;
    @(posedge sys_clk_in) reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run is under two hundred cycles
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(16'h0208 + 16'(i), d);
      chk(d, i == 0 ? 16'h2001 : 16'h0000);
    end
    $display("test reset values done");
    s = 16'h000b;
    for (int k = 0; k < 8; k++) begin
      s = lfsr(s);
      m = s;
      s = lfsr(s);
      h = s;
      s = lfsr(s);
      l = k == 0 ? 16'hffff : k == 1 ? 16'h2005 : k == 2 ? 16'h2006 : s;
      wr(16'h0209, m);
      wr(16'h020a, h);
      wr(16'h0208, l);
      #1 chk(tx_page_out, {h, m, l & 16'hb7ff});
      chk(tx_commit_out, 1'b1);
      rd(16'h0208, d);
      chk(d, low_rb(l, tx_ack_in));
      rd(16'h0209, d);
      chk(d, m);
      rd(16'h020a, d);
      chk(d, h);
    end
    $display("test outgoing page done");
    hop <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(16'h020b + 16'(k), 16'hffff);
      rd(16'h020b, d);
      cap = snap;
      chk(d, cap[15:0]);
      rd(16'h020c, d);
      chk(d, cap[31:16]);
      rd(16'h020d, d);
      chk(d, cap[47:32]);
    end
    hop <= 1'b0;
    $display("test partner capture done");
    @(posedge sys_clk_in) an_rst_in <= 1'b1;
    @(posedge sys_clk_in) an_rst_in <= 1'b0;
    #1 chk(tx_page_out, 48'h2001);
    rd(16'h0208, d);
    chk(d, low_rb(16'h2001, tx_ack_in));
    rd(16'h020c, d);
    chk(d, 16'h0000);
    $display("test autoneg reset done");
    end_sim();
  end
endmodule // test_autoneg_next_page_regs
